//--- serial_data_buffers.sv
`timescale 1ns/10ps
`default_nettype none
module serial_data_buffers
    import serial_buffers_pkg::*;
#(
    parameter int AW = ADDR_W
)
(
    input  wire logic          sys_clk,
    input  wire logic          reset_n,
    input  wire logic          clk_en,
    input  wire logic [AW-1:0] addr,
    input  wire logic [7:0]    wr_data,
    input  wire logic          wr_en,
    input  wire logic          rd_en,
    output logic      [7:0]    rd_data,
    input  wire logic          rx_data_pin,
    output logic               tx_data_pin,
    output logic               sync_clk_out,
    output logic               rx_full_irq,
    output logic               tx_empty_irq
);

    // ************************************************************
    // reset release and parameter check
    // ************************************************************
    generate
        if (AW < ADDR_W)
        begin : g_bad_aw
            $error("address width too small for register map");
        end
    endgenerate

    logic rst_meta;
    logic rst_n_s;

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rst_meta <= 1'b0;
            rst_n_s  <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n_s  <= rst_meta;
        end
    end

    // ************************************************************
    // registers and decoded frame format
    // ************************************************************
    logic [7:0]  serial_mode_config;
    logic [7:0]  baud_div;
    logic [7:0]  serial_control_reg;
    logic [7:0]  transmit_holding;
    logic [7:0]  receive_holding;
    logic        tx_empty;
    logic        rx_full;
    logic        overrun;
    logic        frame_err;
    logic        parity_err;
    logic        tx_end_flag;
    logic        mpb;
    logic        sc;
    logic        async_m;
    logic        mp_m;
    logic        par_m;
    logic        len7;
    logic        stop2;
    logic        gsm;
    logic        tx_en;
    logic        rx_en;
    logic        extra_en;
    logic [3:0]  tx_bits;
    logic [3:0]  rx_last;
    logic [16:0] period;
    logic [16:0] half;
    logic [2:0]  bcp;
    logic        wr_mode;
    logic        wr_txh;
    logic        rd_rxh;

    assign wr_mode  = wr_en && addr == AW'(OFS_MODE);
    assign wr_txh   = wr_en && addr == AW'(OFS_TXH);
    assign rd_rxh   = rd_en && addr == AW'(OFS_RXH);
    assign tx_en    = serial_control_reg[CB_TXEN];
    assign rx_en    = serial_control_reg[CB_RXEN];
    assign sc       = serial_control_reg[CB_SC];
    assign async_m  = sc | ~serial_mode_config[MB_CM];
    assign mp_m     = ~sc & async_m & serial_mode_config[MB_MP];
    assign par_m    = sc ? serial_mode_config[MB_PEN]
                         : async_m & serial_mode_config[MB_PEN] & ~mp_m;
    assign len7     = ~sc & async_m & serial_mode_config[MB_CHR];
    assign stop2    = sc ? ~serial_mode_config[MB_BLK]
                         : async_m & serial_mode_config[MB_STOP];
    assign gsm      = sc & serial_mode_config[MB_GSM];
    assign extra_en = par_m | mp_m;
    assign tx_bits  = async_m ? 4'd8 + {3'd0, ~len7} + {3'd0, extra_en} + {3'd0, stop2} + 4'd1
                              : 4'd8;
    // only the first stop bit is sampled, so a low second stop starts the next frame
    assign rx_last  = async_m ? 4'd8 - {3'd0, len7} + {3'd0, extra_en} + 4'd1 : 4'd8;
    assign bcp      = {serial_control_reg[CB_BCPHI], serial_mode_config[MB_BCP+1:MB_BCP]};
    // smart card: base clocks per bit from the three-bit code, 32 * (code + 1)
    assign period   = 17'(({9'd0, baud_div} + 17'd1)
                      * (sc ? ({14'd0, bcp} + 17'd1) << 5 : OVERSAMPLE));
    assign half     = period >> 1;

    // ************************************************************
    // prescaler
    // ************************************************************
    logic [5:0] presc_cnt;
    logic [5:0] presc_lim;
    logic       tick;

    always_comb
    begin
        case (serial_mode_config[MB_CKS+1:MB_CKS])
            2'b00:   presc_lim = 6'h00;
            2'b01:   presc_lim = 6'h03;
            2'b10:   presc_lim = 6'h0f;
            default: presc_lim = 6'h3f;
        endcase
    end

    assign tick = clk_en && presc_cnt >= presc_lim;

    always_ff @(posedge sys_clk or negedge rst_n_s)
    begin
        if (!rst_n_s)
            presc_cnt <= 6'h00;
        else if (clk_en)
            presc_cnt <= tick ? 6'h00 : presc_cnt + 6'h01;
    end

    // ************************************************************
    // transmitter
    // ************************************************************
    tx_state_t   tx_state;
    logic [11:0] tx_shift_reg;
    logic [3:0]  tx_idx;
    logic [16:0] tx_cnt;
    logic        tx_bit_end;
    logic        tx_frame_end;
    logic        tx_load;
    logic        tx_extra;
    logic [11:0] next_frame;

    assign tx_bit_end   = tick && tx_state == TX_SHIFT && tx_cnt == period - 17'd1;
    assign tx_frame_end = tx_bit_end && tx_idx == tx_bits - 4'd1;
    // the shifter is free when idle or finishing its last bit
    assign tx_load      = tx_en && !tx_empty && clk_en
                          && (tx_state == TX_IDLE || tx_frame_end);
    assign tx_extra     = mp_m ? serial_control_reg[CB_MPT]
                               : parity_of(transmit_holding, len7, serial_mode_config[MB_PODD]);

    always_comb
    begin
        next_frame = 12'hfff;
        if (!async_m)
            next_frame[7:0] = transmit_holding;
        else
        begin
            next_frame[0] = 1'b0;
            if (len7)
            begin
                next_frame[7:1] = transmit_holding[6:0];
                next_frame[8]   = extra_en ? tx_extra : 1'b1;
            end
            else
            begin
                next_frame[8:1] = transmit_holding;
                next_frame[9]   = extra_en ? tx_extra : 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n_s)
    begin
        if (!rst_n_s)
        begin
            tx_state     <= TX_IDLE;
            tx_shift_reg <= 12'hfff;
            tx_idx       <= 4'h0;
            tx_cnt       <= 17'h00000;
            tx_data_pin  <= 1'b1;
        end
        else if (tx_load)
        begin
            tx_state     <= TX_SHIFT;
            tx_shift_reg <= next_frame;
            tx_idx       <= 4'h0;
            tx_cnt       <= 17'h00000;
            tx_data_pin  <= next_frame[0];
        end
        else if (tx_frame_end)
        begin
            tx_state    <= TX_IDLE;
            tx_data_pin <= 1'b1;
        end
        else if (tx_bit_end)
        begin
            tx_shift_reg <= {1'b1, tx_shift_reg[11:1]};
            tx_idx       <= tx_idx + 4'h1;
            tx_cnt       <= 17'h00000;
            tx_data_pin  <= tx_shift_reg[1];
        end
        else if (tick && tx_state == TX_SHIFT)
            tx_cnt <= tx_cnt + 17'h00001;
    end

    // clock output: synchronous frames clock low then high per bit; smart card runs the
    // prescaled clock, held low on request only while gsm timing is on
    always_ff @(posedge sys_clk or negedge rst_n_s)
    begin
        if (!rst_n_s)
            sync_clk_out <= 1'b1;
        else if (clk_en)
        begin
            if (sc)
                sync_clk_out <= (gsm && serial_control_reg[CB_HOLD]) ? 1'b0
                                : sync_clk_out ^ tick;
            else if (!async_m && (tx_load || tx_state == TX_SHIFT) && !tx_frame_end)
                sync_clk_out <= !tx_load && tx_cnt >= half;
            else
                sync_clk_out <= 1'b1;
        end
    end

    // ************************************************************
    // receiver
    // ************************************************************
    rx_state_t   rx_state;
    logic [11:0] rx_shift_reg;
    logic [3:0]  rx_idx;
    logic [16:0] rx_cnt;
    logic        rx_sample;
    logic        rx_done;
    logic [11:0] rx_word;
    logic [7:0]  rx_byte;
    logic        rx_extra;

    assign rx_sample = tick && rx_state == RX_SHIFT && rx_cnt == half;
    assign rx_done   = rx_sample && rx_idx == rx_last;

    always_comb
    begin
        rx_word         = rx_shift_reg;
        rx_word[rx_idx] = rx_data_pin;
        rx_byte         = len7 ? {1'b0, rx_word[7:1]} : rx_word[8:1];
        rx_extra        = len7 ? rx_word[8] : rx_word[9];
    end

    always_ff @(posedge sys_clk or negedge rst_n_s)
    begin
        if (!rst_n_s)
        begin
            rx_state     <= RX_IDLE;
            rx_shift_reg <= 12'h000;
            rx_idx       <= 4'h0;
            rx_cnt       <= 17'h00000;
        end
        else if (clk_en)
        begin
            case (rx_state)
                RX_IDLE:
                begin
                    if (rx_en && async_m && !rx_data_pin)
                    begin
                        rx_state <= RX_SHIFT;
                        rx_idx   <= 4'h0;
                        rx_cnt   <= 17'h00000;
                    end
                    else if (rx_en && !async_m && tx_load)
                    begin
                        rx_state <= RX_SHIFT;
                        rx_idx   <= 4'h1;
                        rx_cnt   <= 17'h00000;
                    end
                end
                RX_SHIFT:
                begin
                    if (rx_sample)
                        rx_shift_reg <= rx_word;
                    if (rx_done || !rx_en || (rx_sample && rx_idx == 4'h0 && rx_data_pin))
                        rx_state <= RX_IDLE;
                    else if (tick && rx_cnt == period - 17'd1)
                    begin
                        rx_cnt <= 17'h00000;
                        rx_idx <= rx_idx + 4'h1;
                    end
                    else if (tick)
                        rx_cnt <= rx_cnt + 17'h00001;
                end
                default: rx_state <= RX_IDLE;
            endcase
        end
    end

    // ************************************************************
    // register port, status and events
    // ************************************************************
    always_ff @(posedge sys_clk or negedge rst_n_s)
    begin
        if (!rst_n_s)
        begin
            serial_mode_config <= MODE_RST;
            baud_div           <= BAUD_RST;
            serial_control_reg <= CTRL_RST;
            transmit_holding   <= TXH_RST;
        end
        else if (clk_en && wr_en)
        begin
            // format fields would corrupt a frame in flight, so they lock while enabled
            if (wr_mode && !tx_en && !rx_en)
                serial_mode_config <= wr_data;
            if (addr == AW'(OFS_BAUD) && !tx_en && !rx_en)
                baud_div <= wr_data;
            if (addr == AW'(OFS_CTRL))
                serial_control_reg <= (tx_en || rx_en)
                    ? {serial_control_reg[CB_SC], wr_data[6:0]} : wr_data;
            if (wr_txh)
                transmit_holding <= wr_data;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n_s)
    begin
        if (!rst_n_s)
        begin
            tx_empty     <= 1'b1;
            tx_end_flag  <= 1'b1;
            tx_empty_irq <= 1'b0;
        end
        else if (clk_en)
        begin
            tx_empty_irq <= tx_load;
            // the shifter load wins over a write in the same cycle
            tx_empty     <= tx_load | (tx_empty & ~wr_txh);
            if ((gsm ? tx_bit_end && tx_idx == GSM_TX_END_FLAG - 4'd1 : tx_frame_end)
                && tx_empty && !tx_load)
                tx_end_flag <= 1'b1;
            else if (tx_load)
                tx_end_flag <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n_s)
    begin
        if (!rst_n_s)
        begin
            receive_holding <= RXH_RST;
            rx_full         <= 1'b0;
            overrun         <= 1'b0;
            frame_err       <= 1'b0;
            parity_err      <= 1'b0;
            mpb             <= 1'b0;
            rx_full_irq     <= 1'b0;
        end
        else if (clk_en)
        begin
            rx_full_irq <= rx_done && !rx_full;
            if (rx_done && !rx_full)
            begin
                receive_holding <= rx_byte;
                mpb             <= mp_m & rx_extra;
            end
            rx_full <= (rx_done && !rx_full) || (rx_full && !rd_rxh);
            if (rx_done && rx_full)
                overrun <= 1'b1;
            else if (wr_en && addr == AW'(OFS_STAT) && !wr_data[SB_OVR])
                overrun <= 1'b0;
            if (rx_done && async_m && !rx_data_pin)
                frame_err <= 1'b1;
            else if (wr_en && addr == AW'(OFS_STAT) && !wr_data[SB_FERR])
                frame_err <= 1'b0;
            if (rx_done && par_m
                && parity_of(rx_byte, len7, serial_mode_config[MB_PODD]) != rx_extra)
                parity_err <= 1'b1;
            else if (wr_en && addr == AW'(OFS_STAT) && !wr_data[SB_PERR])
                parity_err <= 1'b0;
        end
    end

    // shift registers have no address, so they never reach the port
    always_ff @(posedge sys_clk or negedge rst_n_s)
    begin
        if (!rst_n_s)
            rd_data <= 8'h00;
        else if (clk_en)
        begin
            rd_data <= 8'h00;
            if (rd_en)
            begin
                case (addr)
                    AW'(OFS_MODE): rd_data <= serial_mode_config;
                    AW'(OFS_BAUD): rd_data <= baud_div;
                    AW'(OFS_CTRL): rd_data <= serial_control_reg;
                    AW'(OFS_TXH):  rd_data <= transmit_holding;
                    AW'(OFS_STAT): rd_data <= {tx_empty, rx_full, overrun, frame_err,
                                               parity_err, tx_end_flag, mpb, 1'b0};
                    AW'(OFS_RXH):  rd_data <= receive_holding;
                    default:       rd_data <= 8'h00;
                endcase
            end
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n_s);

    property p_rdr_ro;
        clk_en && wr_en && addr == AW'(OFS_RXH) && !rx_done |=> $stable(receive_holding);
    endproperty
    a_rdr_ro: assert property (p_rdr_ro) else $error("receive holding changed on write");

    property p_rx_move;
        clk_en && rx_done && !rx_full |=> rx_full && receive_holding == $past(rx_byte)
                                          ##0 rx_full_irq;
    endproperty
    a_rx_move: assert property (p_rx_move) else $error("frame not moved to holding");

    property p_ovr;
        clk_en && rx_done && rx_full |=> overrun && $stable(receive_holding);
    endproperty
    a_ovr: assert property (p_ovr) else $error("overrun not flagged");

    property p_tx_load;
        clk_en && tx_state == TX_IDLE && tx_en && !tx_empty |=> tx_state == TX_SHIFT
                                   && tx_empty && tx_empty_irq && (!async_m || !tx_data_pin);
    endproperty
    a_tx_load: assert property (p_tx_load) else $error("pending data not loaded");

    property p_no_gap;
        tx_frame_end && tx_en && !tx_empty |=> tx_state == TX_SHIFT && tx_idx == 4'h0;
    endproperty
    a_no_gap: assert property (p_no_gap) else $error("gap between frames");

    property p_tdr_rw;
        clk_en && wr_txh |=> transmit_holding == $past(wr_data);
    endproperty
    a_tdr_rw: assert property (p_tdr_rw) else $error("transmit holding write lost");

    property p_presc;
        serial_mode_config[1:0] == 2'b00 && clk_en |-> tick;
    endproperty
    a_presc: assert property (p_presc) else $error("undivided prescale not ticking");

    property p_mode_lock;
        clk_en && wr_mode && (tx_en || rx_en) |=> $stable(serial_mode_config);
    endproperty
    a_mode_lock: assert property (p_mode_lock) else $error("mode changed while enabled");

    property p_idle_line;
        tx_state == TX_IDLE && $past(tx_state) == TX_IDLE |-> tx_data_pin;
    endproperty
    a_idle_line: assert property (p_idle_line) else $error("line not idle high");

    c_tx_frame: cover property (tx_frame_end);
    c_rx_frame: cover property (rx_done && !rx_full);
    c_overrun:  cover property (rx_done && rx_full);
    c_b2b:      cover property (tx_frame_end && tx_load);

endmodule : serial_data_buffers
`default_nettype wire

//--- serial_buffers_pkg.sv
//
// Behaviour
// - a completed received frame moves from the receive shifter into receive_holding unless receive_holding is still unread
// - receive_holding is eight bits, readable, and ignores writes
// - a frame completing while receive_holding is unread flags overrun
// - with the transmit shifter empty and data pending, load it and send
// - pending data at the end of a frame loads at once, without a gap
// - transmit_holding is eight bits, read and written at any time
// - prescale_sel divides the clock by 1, 4, 16 or 64
// - multiproc_en in asynchronous mode uses the multiprocessor format without parity
// - stop bit field gives one or two transmitted stops; receive checks one
// - parity_odd_sel picks even (0) or odd (1) parity both ways
// - parity_en in asynchronous mode adds parity on transmit and checks on receive
// - char_len_sel picks 8 or 7 data bits in asynchronous mode only
// - seven bit characters go least significant bit first, bit 7 unsent
// - comm_mode_sel picks asynchronous (0) or clock synchronous (1)
// - serial_mode_config accepts writes only while both enables are clear
// - smart_card_sel switches serial_mode_config between normal and smart card layouts
// - smart card bit period uses base_clk_count_sel with base_clk_count_hi
// - block_xfer_en in smart card operation cuts the transmitted frame from two stop bits to one
// - gsm_timing_en sets tx_end_flag at 11 bit times and allows clock hold
// - neither shift register is reachable from the register port
// - with the transmit enable set, writing transmit_holding starts transmission
// - with the receive enable set, reception starts on a start bit or clock
package serial_buffers_pkg;

    localparam int          ADDR_W     = 20;
    localparam logic [19:0] OFS_MODE   = 20'h8a020;
    localparam logic [19:0] OFS_BAUD   = 20'h8a021;
    localparam logic [19:0] OFS_CTRL   = 20'h8a022;
    localparam logic [19:0] OFS_TXH    = 20'h8a023;
    localparam logic [19:0] OFS_STAT   = 20'h8a024;
    localparam logic [19:0] OFS_RXH    = 20'h8a025;

    localparam int MB_CKS  = 0;
    localparam int MB_MP   = 2;
    localparam int MB_STOP = 3;
    localparam int MB_BCP  = 2;
    localparam int MB_PODD = 4;
    localparam int MB_PEN  = 5;
    localparam int MB_CHR  = 6;
    localparam int MB_BLK  = 6;
    localparam int MB_CM   = 7;
    localparam int MB_GSM  = 7;

    localparam int CB_MPT   = 0;
    localparam int CB_BCPHI = 1;
    localparam int CB_HOLD  = 2;
    localparam int CB_RXEN  = 4;
    localparam int CB_TXEN  = 5;
    localparam int CB_SC    = 7;

    localparam int SB_MPB  = 1;
    localparam int SB_TX_END_FLAG = 2;
    localparam int SB_PERR = 3;
    localparam int SB_FERR = 4;
    localparam int SB_OVR  = 5;
    localparam int SB_RXF  = 6;
    localparam int SB_TXE  = 7;

    localparam logic [7:0]  MODE_RST   = 8'h00;
    localparam logic [7:0]  BAUD_RST   = 8'h0f;
    localparam logic [7:0]  CTRL_RST   = 8'h00;
    localparam logic [7:0]  TXH_RST    = 8'hff;
    localparam logic [7:0]  RXH_RST    = 8'h00;
    localparam logic [16:0] OVERSAMPLE = 17'h00010;
    localparam logic [3:0]  GSM_TX_END_FLAG   = 4'hb;

    typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SHIFT = 2'b10} tx_state_t;
    typedef enum logic [1:0] {RX_IDLE = 2'b01, RX_SHIFT = 2'b10} rx_state_t;

    function automatic logic parity_of(input logic [7:0] d, input logic len7, input logic odd);
        parity_of = (^d[6:0]) ^ (d[7] & ~len7) ^ odd;
    endfunction : parity_of

endpackage : serial_buffers_pkg

//--- serial_peer.sv
`timescale 1ns/10ps
`default_nettype none
module serial_peer
#(
    parameter int BIT = 16
)
(
    input  wire logic clk,
    input  wire logic line_in,
    output logic      line_out
);
    // ****
    // far end: 8N1 sender and receiver
    // ****
    logic [7:0] got[$];
    int         st[$];
    int         cyc = 0;
    logic [7:0] sh;
    initial line_out = 1'b1;
    always @(posedge clk) cyc <= cyc + 1;
    task automatic send(input logic [7:0] d);
        logic [9:0] f;
        f = {1'b1, d, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            line_out <= f[i];
            repeat (BIT) @(posedge clk);
        end
    endtask : send
    // start times kept so the bench can spot a gap between frames
    always
    begin
        @(negedge line_in);
        st.push_back(cyc);
        repeat (BIT / 2) @(posedge clk);
        for (int i = 0; i < 8; i++)
        begin
            repeat (BIT) @(posedge clk);
            sh = {line_in, sh[7:1]};
        end
        got.push_back(sh);
        repeat (BIT) @(posedge clk);
    end
endmodule : serial_peer
`default_nettype wire

//--- tb_serial_data_buffers.sv
`timescale 1ns/10ps
`default_nettype none
module tb_serial_data_buffers;
    import serial_buffers_pkg::*;
    logic        sys_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [19:0] addr    = '0;
    logic [7:0]  wr_data = '0;
    logic        wr_en   = 1'b0;
    logic        rd_en   = 1'b0;
    logic [7:0]  rd_data;
    logic        rxd;
    logic        txd;
    logic        full;
    logic        empty_irq;
    logic        sclk;
    int          nfull     = 0;
    int          nempty    = 0;
    int          nslow     = 0;
    int          bad_count = 0;
    int          checked   = 0;
    always #10 sys_clk = ~sys_clk;
    always @(posedge sys_clk)
    begin
        if (full === 1'b1) nfull++;
        if (empty_irq === 1'b1) nempty++;
        // the clock pin is unknown until the first edge under reset
        if (reset_n && sclk !== 1'b1) nslow++;
    end
    serial_data_buffers dut (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(1'b1),
        .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .rx_data_pin(rxd), .tx_data_pin(txd), .sync_clk_out(sclk), .rx_full_irq(full),
        .tx_empty_irq(empty_irq));
    serial_peer peer (.clk(sys_clk), .line_in(txd), .line_out(rxd));
    task automatic stop_test;
        if (bad_count == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : stop_test
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: %h not %h", $time, seen, exp);
        end
    endtask : check
    // one idle cycle after each strobe so no strobe is assigned twice at one edge
    task automatic wr(input logic [19:0] a, input logic [7:0] d);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge sys_clk);
        wr_en <= 1'b0;
        @(posedge sys_clk);
    endtask : wr
    task automatic rd(input logic [19:0] a, input logic [7:0] e);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge sys_clk);
        rd_en <= 1'b0;
        // read data stand only in the cycle right after the strobe
        @(negedge sys_clk);
        check({24'h0, rd_data}, {24'h0, e});
        @(posedge sys_clk);
    endtask : rd
    // ****
    // scenarios
    // ****
    task automatic t_regs;
        rd(OFS_MODE, MODE_RST);
        rd(OFS_TXH, TXH_RST);
        wr(OFS_RXH, 8'h5a);
        rd(OFS_RXH, RXH_RST);
        rd(20'h8a02f, 8'h00);
        wr(OFS_BAUD, 8'h00);
        wr(OFS_MODE, 8'h00);
        wr(OFS_CTRL, 8'h30);
        wr(OFS_MODE, 8'h40);
        rd(OFS_MODE, 8'h00);
    endtask : t_regs
    task automatic t_tx;
        wr(OFS_TXH, 8'ha5);
        wr(OFS_TXH, 8'h0f);
        rd(OFS_TXH, 8'h0f);
        for (int i = 0; i < 600 && peer.got.size() < 2; i++) @(posedge sys_clk);
        check(peer.got[0], 8'ha5);
        check(peer.got[1], 8'h0f);
        check(32'(peer.st[1] - peer.st[0]), 160);
        check(nempty, 2);
    endtask : t_tx
    task automatic t_rx;
        peer.send(8'h96);
        check(nfull, 1);
        rd(OFS_RXH, 8'h96);
        peer.send(8'h11);
        peer.send(8'h22);
        rd(OFS_STAT, 8'he4);
        rd(OFS_RXH, 8'h11);
    endtask : t_rx
    // seven data bits with even parity: the peer takes the parity bit as its top bit
    task automatic t_fmt;
        wr(OFS_CTRL, 8'h00);
        wr(OFS_MODE, 8'h60);
        wr(OFS_CTRL, 8'h30);
        wr(OFS_TXH, 8'h85);
        for (int i = 0; i < 600 && peer.got.size() < 3; i++) @(posedge sys_clk);
        check(peer.got[2], 8'h05);
        peer.send(8'h05);
        rd(OFS_RXH, 8'h05);
        peer.send(8'h85);
        rd(OFS_STAT, 8'hec);
        rd(OFS_RXH, 8'h05);
        check(nslow, 0);
    endtask : t_fmt
    task automatic t_sc;
        wr(OFS_CTRL, 8'h00);
        wr(OFS_CTRL, 8'h80);
        wr(OFS_MODE, 8'h20);
        rd(OFS_CTRL, 8'h80);
        @(negedge sys_clk);
        nslow = 0;
        repeat (8) @(posedge sys_clk);
        @(negedge sys_clk);
        check(nslow, 4);
    endtask : t_sc
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        bad_count++;
        stop_test();
    end
    initial
    begin
        repeat (8) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        t_regs();
        t_tx();
        t_rx();
        t_fmt();
        t_sc();
        stop_test();
    end
endmodule : tb_serial_data_buffers
`default_nettype wire
